// ==== lasm_ctrl.sv ====
// link activation and deactivation state controller, top level
module lasm_ctrl #(
  parameter int TICK_DIV = lasm_pkg::CYC_PER_MS,           // cycles per ms, shorten for simulation
  parameter int COLD_MS = lasm_pkg::COLD_START_MS,         // cold-start limit in ms
  parameter int WARM_MS = lasm_pkg::WARM_START_MS,         // warm-start limit in ms
  parameter int WRES_MS = lasm_pkg::WARM_RESUME_MS,        // warm-resume limit in ms
  parameter int RERR_MS = lasm_pkg::RESUME_ERR_MS,         // resume-on-error limit in ms
  parameter int SYNC_MS = lasm_pkg::SYNC_LOSS_MS,          // sync_loss_timeout in ms
  parameter bit IDLE_EN = 1'b1                             // idle state supported
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic hsDone,                                 // handshake concluded, pulse
  input wire logic hsModeSel,                              // handshake chose this mode
  input wire logic powerUpReq,                             // power-up request, pulse
  input wire logic powerFail,                              // local power failure, level
  input wire logic quietReq,                               // local terminate request, pulse
  input wire logic peerQuietPin,                           // terminate signal from the peer pin
  input wire logic syncLost,                               // frame, energy or timing lost, level
  input wire logic actDone,                                // training reached steady, pulse
  input wire logic actFail,                                // training gave up, pulse
  input wire logic idleReq,                                // broadband call released, pulse
  input wire logic wakeReq,                                // back-to-service wake-up, pulse
  input wire logic crLoad,                                 // trigger handshake applies newSet, pulse
  input wire lasm_pkg::lasm_set_t newSet,                  // set to apply on crLoad
  input wire lasm_pkg::lasm_set_t defaultSet,              // set used by cold-start
  input wire lasm_pkg::lasm_set_t warmSet,                 // set used by warm-start
  output lasm_pkg::lasm_link_e linkState,                  // visible link state
  output lasm_pkg::lasm_proc_e procState,                  // running activation procedure
  output lasm_pkg::lasm_set_t currentParamSet,             // set applied by the transmitters
  output lasm_pkg::lasm_set_t resumeOnErrorSet,            // set for resume-on-error
  output lasm_pkg::lasm_set_t warmResumeSet,               // set for warm-resume
  output logic [lasm_pkg::MS_W-1:0] actTimeMs,             // last activation time in ms
  output logic actTimeout,                                 // activation ran over its limit, pulse
  output logic actStart,                                   // a procedure starts, pulse
  output logic paramErr,                                   // crLoad refused, pulse
  output logic setChanged,                                 // current set changed, pulse
  output logic quietOut,                                   // terminate signal towards the peer
  output logic userDataEn,                                 // user data transport enabled
  output logic monitorEn                                   // frame sync and event monitoring on
);
  import lasm_pkg::*;
  // ----------------------------------------------------------------
  // elaboration checks
  // ----------------------------------------------------------------
  localparam int MS_MAX = (1 << MS_W) - 1;
  initial begin
    if (COLD_MS < 1 || COLD_MS >= MS_MAX) $error("COLD_MS out of range");
    if (WARM_MS < 1 || WARM_MS >= MS_MAX) $error("WARM_MS out of range");
    if (WRES_MS < 1 || WRES_MS >= MS_MAX) $error("WRES_MS out of range");
    if (RERR_MS < 1 || RERR_MS >= MS_MAX) $error("RERR_MS out of range");
    if (SYNC_MS < 1 || SYNC_MS >= MS_MAX) $error("SYNC_MS out of range");
  end
  // ----------------------------------------------------------------
  // timing resources
  // ----------------------------------------------------------------
  lasm_tmr_if tbus ();                                     // tick, restart, limit, elapsed
  lasm_tick_div #(.DIV(TICK_DIV)) u_div (
    .clk(clk),
    .sys_rst(sys_rst),
    .tb(tbus.div)
  );
  lasm_ms_timer u_tmr (
    .clk(clk),
    .sys_rst(sys_rst),
    .tb(tbus.tmr)
  );
  // ----------------------------------------------------------------
  // peer terminate pin synchroniser, second stage is the only reader
  // ----------------------------------------------------------------
  logic peerQuietS1_r;                                     // first stage, metastable
  logic peerQuietS2_r;                                     // second stage, safe to use
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      peerQuietS1_r <= 1'b0;
      peerQuietS2_r <= 1'b0;
    end else begin
      peerQuietS1_r <= peerQuietPin;
      peerQuietS2_r <= peerQuietS1_r;
    end
  end
  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  lasm_state_e state_r;                                    // controller state
  lasm_state_e state_nxt;
  lasm_link_e link_r;
  lasm_link_e link_nxt;
  lasm_proc_e proc_r;
  lasm_proc_e proc_nxt;
  lasm_set_t cur_r;                                        // current_param_set
  lasm_set_t cur_nxt;
  lasm_set_t re_r;                                         // resume_on_error_set
  lasm_set_t re_nxt;
  lasm_set_t wr_r;                                         // warm_resume_set
  lasm_set_t wr_nxt;
  logic [MS_W-1:0] actTime_r;
  logic actTimeout_r;
  logic actStart_r;
  logic paramErr_r;
  logic setChanged_r;
  logic quietOut_r;
  logic userData_r;
  logic monitor_r;
  // ----------------------------------------------------------------
  // decode of events
  // ----------------------------------------------------------------
  wire terminate = quietReq || peerQuietS2_r || powerFail;
  wire inActivation = (state_r == ST_COLD) || (state_r == ST_WARM) ||
                      (state_r == ST_RERR) || (state_r == ST_WRES);
  wire actOk = inActivation && actDone;
  wire actBad = inActivation && !actDone && (actFail || tbus.expired);
  // a failed cold-start stays in cold-start, so it counts as a fresh entry
  wire entering = (state_nxt != state_r) || actBad;
  wire enterSteady = entering && (state_nxt == ST_STEADY);
  wire enterIdle = entering && (state_nxt == ST_IDLE);
  wire crWindow = (state_r == ST_STEADY) || (state_r == ST_IDLE);
  // ----------------------------------------------------------------
  // legality of a requested set: every enabled carrier in range
  // ----------------------------------------------------------------
  logic [CARRIERS-1:0] carOk;
  genvar gi;
  generate
    for (gi = 0; gi < CARRIERS; gi++) begin : g_chk
      assign carOk[gi] = (newSet[gi].symRateMul == 8'h00) ||
                         ((newSet[gi].constBits >= CONST_MIN) && (newSet[gi].constBits <= CONST_MAX) &&
                          (newSet[gi].excessBw >= EXBW_MIN) && (newSet[gi].excessBw <= EXBW_MAX) &&
                          (newSet[gi].cenFreqMul != 12'h000));
    end
  endgenerate
  wire setLegal = &carOk;
  wire crAccept = crLoad && crWindow && setLegal && !terminate;
  wire crRefuse = crLoad && !crAccept;
  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    state_nxt = state_r;
    if (terminate && state_r != ST_OFF) begin
      // cold-start falls back to power-off, every other state to power down
      state_nxt = (state_r == ST_COLD) ? ST_OFF : ST_PDOWN;
    end else begin
      unique case (state_r)
        ST_OFF: begin
          if (hsDone && hsModeSel) begin
            state_nxt = ST_COLD;
          end
        end
        ST_COLD: begin
          if (actOk) begin
            state_nxt = ST_STEADY;
          end else if (actBad) begin
            state_nxt = ST_COLD;                                            // retry with default set
          end
        end
        ST_WARM: begin
          if (actOk) begin
            state_nxt = ST_STEADY;
          end else if (actBad) begin
            state_nxt = ST_COLD;
          end
        end
        ST_RERR, ST_WRES: begin
          if (actOk) begin
            state_nxt = ST_STEADY;
          end else if (actBad) begin
            state_nxt = ST_WARM;
          end
        end
        ST_STEADY: begin
          if (syncLost) begin
            state_nxt = ST_SYNCLOSS;
          end else if (idleReq && IDLE_EN) begin
            state_nxt = ST_IDLE;
          end
        end
        ST_SYNCLOSS: begin
          if (!syncLost) begin
            state_nxt = ST_STEADY;
          end else if (tbus.expired) begin
            state_nxt = ST_RERR;
          end
        end
        ST_PDOWN: begin
          if (powerUpReq) begin
            state_nxt = ST_WARM;
          end
        end
        ST_IDLE: begin
          if (wakeReq) begin
            state_nxt = ST_WRES;
          end
        end
        default: state_nxt = ST_OFF;
      endcase
    end
  end
  // ----------------------------------------------------------------
  // timer control; the restart lands on the same edge as the state change
  // ----------------------------------------------------------------
  always_comb begin
    unique case (state_r)
      ST_COLD: tbus.limitMs = MS_W'(COLD_MS);
      ST_WARM: tbus.limitMs = MS_W'(WARM_MS);
      ST_WRES: tbus.limitMs = MS_W'(WRES_MS);
      ST_RERR: tbus.limitMs = MS_W'(RERR_MS);
      ST_SYNCLOSS: tbus.limitMs = MS_W'(SYNC_MS);
      default: tbus.limitMs = '1;                                           // no limit applies
    endcase
  end
  assign tbus.restart = entering;
  // ----------------------------------------------------------------
  // visible link state and running procedure
  // ----------------------------------------------------------------
  always_comb begin
    link_nxt = LK_ACTIVATING;
    proc_nxt = PR_NONE;
    unique case (state_nxt)
      ST_OFF: link_nxt = LK_POWER_OFF;
      ST_STEADY: link_nxt = LK_STEADY;
      ST_SYNCLOSS: link_nxt = LK_SYNC_LOSS;
      ST_PDOWN: link_nxt = LK_POWER_DOWN;
      ST_IDLE: link_nxt = LK_IDLE;
      ST_COLD: proc_nxt = PR_COLD;
      ST_WARM: proc_nxt = PR_WARM;
      ST_RERR: proc_nxt = PR_RERR;
      ST_WRES: proc_nxt = PR_WRES;
      default: link_nxt = LK_POWER_OFF;
    endcase
  end
  // ----------------------------------------------------------------
  // parameter sets: procedure entry loads, trigger handshake overwrites
  // ----------------------------------------------------------------
  wire procEntry = entering && (proc_nxt != PR_NONE);
  always_comb begin
    cur_nxt = cur_r;
    re_nxt = re_r;
    wr_nxt = wr_r;
    if (procEntry) begin
      unique case (proc_nxt)
        PR_COLD: cur_nxt = defaultSet;
        PR_WARM: cur_nxt = warmSet;
        PR_RERR: cur_nxt = re_r;
        PR_WRES: cur_nxt = wr_r;
        default: cur_nxt = cur_r;
      endcase
    end else if (crAccept) begin
      cur_nxt = newSet;
    end
    // resume-on-error set follows the set in force while steady or idle, warm-resume set is taken on entry to steady only
    if (enterSteady || enterIdle || (crWindow && !procEntry)) begin
      re_nxt = cur_nxt;
    end
    if (enterSteady) begin
      wr_nxt = cur_nxt;
    end
  end
  // ----------------------------------------------------------------
  // state and set registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      state_r <= ST_OFF;
      link_r <= LK_POWER_OFF;
      proc_r <= PR_NONE;
      cur_r <= '0;
      re_r <= '0;
      wr_r <= '0;
    end else begin
      state_r <= state_nxt;
      link_r <= link_nxt;
      proc_r <= proc_nxt;
      cur_r <= cur_nxt;
      re_r <= re_nxt;
      wr_r <= wr_nxt;
    end
  end
  // ----------------------------------------------------------------
  // activation timing: elapsed ms captured when training reports done during a procedure
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      actTime_r <= '0;
      actTimeout_r <= 1'b0;
      actStart_r <= 1'b0;
    end else begin
      if (actOk) begin
        actTime_r <= tbus.elapsedMs;
      end
      actTimeout_r <= actBad && !actFail && !terminate;
      actStart_r <= procEntry;
    end
  end
  // ----------------------------------------------------------------
  // status pulses and transport enables
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      paramErr_r <= 1'b0;
      setChanged_r <= 1'b0;
      quietOut_r <= 1'b0;
      userData_r <= 1'b0;
      monitor_r <= 1'b0;
    end else begin
      paramErr_r <= crRefuse;
      // a change is flagged so the peer can mirror it
      setChanged_r <= (cur_nxt != cur_r);
      // only local causes are passed on, never the peer's own signal echoed back
      quietOut_r <= (quietReq || powerFail) && (state_r != ST_OFF);
      userData_r <= (state_nxt == ST_STEADY);
      monitor_r <= (state_nxt == ST_STEADY) || (state_nxt == ST_IDLE);
    end
  end
  // ----------------------------------------------------------------
  // outputs, each straight from a flip-flop
  // ----------------------------------------------------------------
  assign linkState = link_r;
  assign procState = proc_r;
  assign currentParamSet = cur_r;
  assign resumeOnErrorSet = re_r;
  assign warmResumeSet = wr_r;
  assign actTimeMs = actTime_r;
  assign actTimeout = actTimeout_r;
  assign actStart = actStart_r;
  assign paramErr = paramErr_r;
  assign setChanged = setChanged_r;
  assign quietOut = quietOut_r;
  assign userDataEn = userData_r;
  assign monitorEn = monitor_r;
endmodule

// ==== lasm_pkg.sv ====
// constants, types and timing figures shared by the link activation controller
package lasm_pkg;
  // ----------------------------------------------------------------
  // clock and timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 20;                       // 50 MHz core clock
  localparam int MS_NS = 1000000;                          // one millisecond in ns
  localparam int CYC_PER_MS = MS_NS / CLK_PERIOD_NS;       // cycles per ms tick
  localparam int MS_W = 14;                                // ms counter width
  localparam int COLD_START_MS = 10000;                    // cold-start limit
  localparam int WARM_START_MS = 5000;                     // warm-start limit
  localparam int WARM_RESUME_MS = 100;                     // warm-resume limit
  localparam int RESUME_ERR_MS = 300;                      // resume-on-error limit
  localparam int SYNC_LOSS_MS = 200;                       // sync_loss_timeout
  // ----------------------------------------------------------------
  // transmission_param_set layout
  // ----------------------------------------------------------------
  localparam int CARRIERS = 4;                             // 1D, 2D, 1U, 2U
  localparam logic [3:0] CONST_MIN = 4'h1;                 // bits per symbol, least
  localparam logic [3:0] CONST_MAX = 4'hc;                 // bits per symbol, most
  localparam logic [4:0] EXBW_MIN = 5'h0a;                 // excess bandwidth 0.10 in hundredths
  localparam logic [4:0] EXBW_MAX = 5'h14;                 // excess bandwidth 0.20 in hundredths
  typedef struct packed {
    logic [7:0] symRateMul;                                // symbol rate / 33.75 kbaud, 0 = carrier off
    logic [4:0] excessBw;                                  // excess bandwidth in hundredths
    logic [3:0] constBits;                                 // constellation, bits per symbol
    logic [11:0] cenFreqMul;                               // centre frequency / 16.875 kHz
  } lasm_carrier_s;
  typedef lasm_carrier_s [CARRIERS-1:0] lasm_set_t;        // one whole parameter set
  // ----------------------------------------------------------------
  // state encodings
  // ----------------------------------------------------------------
  typedef enum logic [3:0] {
    ST_OFF, ST_COLD, ST_WARM, ST_RERR, ST_WRES, ST_STEADY, ST_SYNCLOSS, ST_PDOWN, ST_IDLE
  } lasm_state_e;
  typedef enum logic [2:0] {
    LK_POWER_OFF, LK_STEADY, LK_SYNC_LOSS, LK_POWER_DOWN, LK_IDLE, LK_ACTIVATING
  } lasm_link_e;
  typedef enum logic [2:0] {
    PR_NONE, PR_COLD, PR_WARM, PR_RERR, PR_WRES
  } lasm_proc_e;
endpackage

// ==== lasm_tmr_if.sv ====
// carrier between the controller, the ms tick divider and the procedure timer
interface lasm_tmr_if;
  import lasm_pkg::*;
  logic tick;                                              // one-cycle ms enable
  logic restart;                                           // count restarts from zero
  logic [MS_W-1:0] limitMs;                                // limit of the running interval
  logic [MS_W-1:0] elapsedMs;                              // ms since the last restart
  logic expired;                                           // elapsed has reached the limit
  modport div (output tick);
  modport tmr (input tick, input restart, input limitMs, output elapsedMs, output expired);
  modport ctl (output restart, output limitMs, input elapsedMs, input expired);
endinterface

// ==== lasm_tick_div.sv ====
// free-running millisecond tick divider
module lasm_tick_div #(
  parameter int DIV = lasm_pkg::CYC_PER_MS
) (
  input wire logic clk,
  input wire logic sys_rst,
  lasm_tmr_if.div tb
);
  import lasm_pkg::*;
  localparam int CW = $clog2(DIV + 1);
  initial if (DIV < 2) $error("tick divider needs DIV of 2 or more");
  logic [CW-1:0] cnt_r;                                    // cycles within the current ms
  logic tick_r;                                            // registered tick pulse
  wire wrap = (cnt_r == CW'(DIV - 1));
  // ----------------------------------------------------------------
  // counter; never restarted so all timers share one time base
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      cnt_r <= '0;
      tick_r <= 1'b0;
    end else begin
      cnt_r <= wrap ? '0 : cnt_r + 1'b1;
      tick_r <= wrap;
    end
  end
  assign tb.tick = tick_r;
endmodule

// ==== lasm_ms_timer.sv ====
// procedure timer counting ms ticks since its last restart
module lasm_ms_timer (
  input wire logic clk,
  input wire logic sys_rst,
  lasm_tmr_if.tmr tb
);
  import lasm_pkg::*;
  logic [MS_W-1:0] ms_r;                                   // saturating ms count
  wire sat = &ms_r;
  // ----------------------------------------------------------------
  // count; a restart wins over a tick in the same cycle
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (sys_rst || tb.restart) begin
      ms_r <= '0;
    end else if (tb.tick && !sat) begin
      ms_r <= ms_r + 1'b1;
    end
  end
  assign tb.elapsedMs = ms_r;
  // expiry looks at the count alone: the restart is decoded from the next state,
  // which itself reads expiry, so gating with restart would close a loop
  assign tb.expired = (ms_r >= tb.limitMs);
endmodule

// ==== lasm_ctrl_monitor.sv ====
// checker watching the link controller ports
module lasm_mon #(parameter int TICK_DIV = 10, parameter int SYNC_MS = 4) (
  input wire logic clk, sys_rst, hsDone, hsModeSel, quietReq, peerQuietPin,
  input wire logic powerFail, syncLost, actDone, idleReq, actStart, userDataEn, monitorEn,
  input wire lasm_pkg::lasm_set_t defaultSet, currentParamSet, resumeOnErrorSet, warmResumeSet,
  input wire lasm_pkg::lasm_link_e linkState,
  input wire lasm_pkg::lasm_proc_e procState);
  timeunit 1ns; timeprecision 1ns;
  import lasm_pkg::*;
  localparam int SL = SYNC_MS * TICK_DIV + 2; // restart on entry keeps the wait within SYNC_MS ms, two cycles cover expiry and the state register
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  // no terminate seen, the peer pin counted through its synchroniser
  sequence s_calm; (!peerQuietPin)[*3] ##0 (!quietReq && !powerFail); endsequence
  property p_cold; linkState == LK_POWER_OFF && hsDone && hsModeSel
    |=> procState == PR_COLD && currentParamSet == $past(defaultSet); endproperty
  property p_start; procState != PR_NONE && procState != $past(procState) |-> actStart; endproperty
  property p_done; s_calm ##0 (procState != PR_NONE && actDone) |=> linkState == LK_STEADY && userDataEn; endproperty
  property p_sets; linkState == LK_STEADY && $past(linkState) != LK_STEADY
    |-> warmResumeSet == currentParamSet && resumeOnErrorSet == currentParamSet; endproperty
  property p_sync; linkState == LK_SYNC_LOSS |-> ##[0:SL] linkState != LK_SYNC_LOSS; endproperty
  property p_rerr; linkState == LK_ACTIVATING && $past(linkState) == LK_SYNC_LOSS
    |-> procState == PR_RERR && currentParamSet == $past(resumeOnErrorSet); endproperty
  property p_idle; s_calm ##0 (linkState == LK_STEADY && idleReq && !syncLost)
    |=> linkState == LK_IDLE && monitorEn && !userDataEn; endproperty
  property p_qcold; quietReq && procState == PR_COLD |=> linkState == LK_POWER_OFF; endproperty
  a_cold: assert property (p_cold) else $error("cold-start not entered");
  a_start: assert property (p_start) else $error("start pulse missing");
  a_done: assert property (p_done) else $error("steady not reached");
  a_sets: assert property (p_sets) else $error("stored sets stale");
  a_sync: assert property (p_sync) else $error("sync loss outlived timeout");
  a_rerr: assert property (p_rerr) else $error("wrong recovery procedure");
  a_idle: assert property (p_idle) else $error("idle not entered");
  a_qcold: assert property (p_qcold) else $error("terminate in cold-start");
  c_rerr: cover property (procState == PR_RERR);
  c_idle: cover property (linkState == LK_IDLE);
  c_qcold: cover property (quietReq && procState == PR_COLD);
endmodule
bind lasm_ctrl lasm_mon #(.TICK_DIV(TICK_DIV), .SYNC_MS(SYNC_MS)) i_lasm_mon (.clk, .sys_rst, .hsDone,
  .hsModeSel, .quietReq, .peerQuietPin, .powerFail, .syncLost, .actDone, .idleReq, .actStart, .userDataEn,
  .monitorEn, .defaultSet, .currentParamSet, .resumeOnErrorSet, .warmResumeSet, .linkState, .procState);

// ==== lasm_peer.sv ====
// peer transceiver: trains for a random time, can fail or stay mute
module lasm_peer (
  input wire logic clk, quietCmd,
  input wire lasm_pkg::lasm_proc_e procState, failOn, muteOn,
  output logic actDone = 0, actFail = 0, peerQuietPin = 0);
  timeunit 1ns; timeprecision 1ns;
  import lasm_pkg::*;
  lasm_proc_e pp = PR_NONE; // procedure seen last cycle
  int cnt = 0; // cycles spent training
  int dly = 5; // training length, redrawn whenever the count is zero
  always @(posedge clk) begin
    cnt <= (procState != pp || procState == PR_NONE) ? 0 : cnt + 1;
    pp <= procState;
    if (cnt == 0) dly <= 2 + $urandom % 12;
    actDone <= procState != PR_NONE && cnt == dly && procState != failOn && procState != muteOn;
    actFail <= procState != PR_NONE && cnt == dly && procState == failOn;
    peerQuietPin <= quietCmd;
  end
endmodule

// ==== tb_top.sv ====
// self-checking bench for the link activation controller
module tb_top;
  timeunit 1ns; timeprecision 1ns;
  import lasm_pkg::*;
  logic clk = 0, sys_rst = 1, syncLost = 0, actDone, actFail, peerQuietPin;
  logic hsModeSel = 1, powerFail = 0, crLoad = 0, actTimeout, paramErr, setChanged, quietOut;
  logic [MS_W-1:0] actTimeMs;
  logic [5:0] ev = '0; // one-cycle requests
  wire hsDone = ev[0], powerUpReq = ev[1], quietReq = ev[2], idleReq = ev[3], wakeReq = ev[4], quietCmd = ev[5];
  lasm_set_t defaultSet = '0, warmSet = '0;
  lasm_set_t newSet = '0, currentParamSet, resumeOnErrorSet, expSet;
  lasm_link_e linkState; lasm_proc_e procState, failOn = PR_NONE, muteOn = PR_NONE;
  logic [5:0] expQ[$]; logic [5:0] seen = '0; // {link, proc}
  int err_count = 0, num_checks = 0;
  always #10 clk = ~clk;
  lasm_ctrl #(.TICK_DIV(10), .COLD_MS(20), .WARM_MS(10), .WRES_MS(5), .RERR_MS(6), .SYNC_MS(4)) i_lasm_ctrl (
    .clk, .sys_rst, .hsDone, .hsModeSel, .powerUpReq, .powerFail, .quietReq, .peerQuietPin,
    .syncLost, .actDone, .actFail, .idleReq, .wakeReq, .crLoad, .newSet, .defaultSet, .warmSet,
    .linkState, .procState, .currentParamSet, .resumeOnErrorSet, .warmResumeSet(), .actTimeMs,
    .actTimeout, .actStart(), .paramErr, .setChanged, .quietOut, .userDataEn(), .monitorEn());
  lasm_peer i_lasm_peer (.clk, .quietCmd, .procState, .failOn, .muteOn, .actDone, .actFail, .peerQuietPin);
  task automatic chk(input string what, input logic [127:0] got, input logic [127:0] exp);
    num_checks++;
    if (got !== exp) begin err_count++; $display("Error %s exp %h got %h", what, exp, got); end
  endtask
  task automatic finish_test;
    $display("checks %0d errors %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task automatic pulse(input int i);
    ev[i] <= 1'b1; @(posedge clk) ev[i] <= 1'b0;
  endtask
  task automatic waitfor(input logic [5:0] v);
    for (int n = 0; n < 400 && {linkState, procState} !== v; n++) @(posedge clk);
  endtask
  task automatic drain(input int t);
    for (int n = 0; n < 400 && expQ.size() > 0; n++) @(posedge clk);
    chk("pending", 128'(expQ.size()), 128'h0);
    $display("test %0d done", t);
  endtask
  // every change of state is compared with the oldest note
  always @(posedge clk) if (!sys_rst && {linkState, procState} !== seen) begin
    seen <= {linkState, procState};
    chk("state", 128'({linkState, procState}), 128'(expQ.size() > 0 ? expQ.pop_front() : 6'h3f));
  end
  initial begin repeat (20000) @(posedge clk); err_count++; finish_test; end
  initial begin
    void'($urandom(87));
    defaultSet = 116'({$urandom, $urandom, $urandom, $urandom});
    warmSet = 116'({$urandom, $urandom, $urandom, $urandom});
    repeat (20) @(posedge clk); sys_rst <= 1'b0;
    expQ = '{{LK_ACTIVATING, PR_COLD}, {LK_STEADY, PR_NONE}}; pulse(0); drain(1);
    expQ = '{{LK_SYNC_LOSS, PR_NONE}, {LK_STEADY, PR_NONE}}; syncLost <= 1'b1;
    repeat (3) @(posedge clk); syncLost <= 1'b0; drain(2);
    failOn <= PR_RERR; syncLost <= 1'b1;
    expQ = '{{LK_SYNC_LOSS, PR_NONE}, {LK_ACTIVATING, PR_RERR}, {LK_ACTIVATING, PR_WARM}, {LK_STEADY, PR_NONE}};
    waitfor({LK_ACTIVATING, PR_RERR}); syncLost <= 1'b0; drain(3);
    expQ = '{{LK_IDLE, PR_NONE}, {LK_ACTIVATING, PR_WRES}, {LK_STEADY, PR_NONE}}; pulse(3); pulse(4); drain(4);
    muteOn <= PR_WARM;
    expQ = '{{LK_POWER_DOWN, PR_NONE}, {LK_ACTIVATING, PR_WARM}, {LK_ACTIVATING, PR_COLD}, {LK_POWER_OFF, PR_NONE}};
    pulse(5); waitfor({LK_POWER_DOWN, PR_NONE}); pulse(1); waitfor({LK_ACTIVATING, PR_COLD});
    chk("actTimeout", actTimeout, 1'b1);
    pulse(2); drain(5);
    // a handshake that picked another mode must leave power-off alone
    muteOn <= PR_NONE; hsModeSel <= 1'b0; pulse(0); hsModeSel <= 1'b1; repeat (2) @(posedge clk);
    expQ = '{{LK_ACTIVATING, PR_COLD}, {LK_STEADY, PR_NONE}}; pulse(0); drain(6);
    chk("actTimeMs", actTimeMs < 14'd20, 1'b1);
    // legal random set is applied, an illegal constellation is refused
    for (int c = 0; c < CARRIERS; c++)
      newSet[c] <= '{8'($urandom), 5'(10 + $urandom % 11), 4'(1 + $urandom % 12), 12'(1 + $urandom % 4095)};
    crLoad <= 1'b1;
    @(posedge clk) crLoad <= 1'b0;
    expSet = newSet;
    @(posedge clk) chk("currentParamSet", currentParamSet, expSet);
    chk("resumeOnErrorSet", resumeOnErrorSet, expSet);
    chk("setChanged", {setChanged, paramErr}, 2'b10);
    newSet[1] <= '{8'h01, EXBW_MAX, 4'h0, 12'h001}; crLoad <= 1'b1;
    @(posedge clk) crLoad <= 1'b0;
    @(posedge clk) chk("paramErr", {paramErr, currentParamSet}, {1'b1, expSet});
    // local power failure terminates a steady link into power down
    expQ = '{{LK_POWER_DOWN, PR_NONE}}; powerFail <= 1'b1;
    @(posedge clk) powerFail <= 1'b0;
    @(posedge clk) chk("quietOut", quietOut, 1'b1);
    drain(7);
    finish_test;
  end
endmodule
